// ==== hdl/adcrs_regs.svh ====
// Register offsets, field positions, reset values and cycle counts of the converter request sequencer.
`ifndef ADCRS_REGS_SVH
`define ADCRS_REGS_SVH
`define ADCRS_CTRL     6'h00
`define ADCRS_TIM      6'h01
`define ADCRS_PEND     6'h02
`define ADCRS_LDMSK    6'h03
`define ADCRS_QUEUE    6'h04
`define ADCRS_INS      6'h05
`define ADCRS_LIMLO    6'h06
`define ADCRS_TSEL     6'h07
`define ADCRS_LIMHI    6'h08
`define ADCRS_RESCFG   6'h09
`define ADCRS_SRQSEL   6'h0a
`define ADCRS_DIGDIS   6'h0b
`define ADCRS_STATUS   6'h0c
`define ADCRS_DIGIN    6'h0d
`define ADCRS_RES_GRP  3'h2
`define ADCRS_C_RES8   0
`define ADCRS_C_APD    1
`define ADCRS_C_SYNC   2
`define ADCRS_C_MTEST  3
`define ADCRS_C_BWD    4
`define ADCRS_C_LIM    5
`define ADCRS_C_ACC    6
`define ADCRS_C_PPAR   8
`define ADCRS_C_PQ     10
`define ADCRS_C_PINS   12
`define ADCRS_C_EMUX   14
`define ADCRS_Q_RUN    15
`define ADCRS_INS_GO   8
`define ADCRS_CTRL_RST 16'h0000
`define ADCRS_TIM_RST  16'h0303
`define ADCRS_WAKE_CYC 8'h04
`define ADCRS_STEP_MIN 8'h03
`define ADCRS_QDEPTH   3'h4
`endif

// ==== hdl/adcrs_pkg.sv ====
// Types of the converter request sequencer.
`default_nettype none
package adcrs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WAKE  = 3'b001,
    ST_SAMP  = 3'b011,
    ST_CONV  = 3'b010,
    ST_STORE = 3'b110
  } adcrs_state_e;

  typedef enum logic [1:0] {SRC_PAR = 2'b00, SRC_Q = 2'b01, SRC_INS = 2'b10} adcrs_src_e;

  typedef struct packed {
    logic [15:0]      ctrl;
    logic [15:0]      tim;
    logic [8:0]       pend;
    logic [8:0]       ldmsk;
    logic [8:0]       tsel;
    logic [3:0][6:0]  q;
    logic [2:0]       qn;
    logic             qrun;
    logic [6:0]       ins;
    logic             ins_p;
    logic [9:0]       lo;
    logic [9:0]       hi;
    logic [7:0]       wfr;
    logic [7:0]       chain;
    logic [7:0]       srqsel;
    logic [8:0]       digdis;
    logic [7:0][13:0] res;
    logic [7:0]       val;
    adcrs_state_e     st;
    logic [7:0]       cnt;
    logic [3:0]       bitn;
    logic [9:0]       sar;
    logic [3:0]       ch;
    logic [2:0]       tgt;
    logic [13:0]      acc;
    logic [2:0]       accn;
    logic             srq;
    logic [2:0]       srqr;
    logic [8:0]       din_s1;
    logic [8:0]       din_s2;
    logic             cmp_s1;
    logic             cmp_s2;
  } adcrs_conv_s;

  typedef struct packed {
    adcrs_conv_s [1:0] cv;
    logic [2:0]        trg;
    logic [15:0]       rdata;
  } adcrs_state_s;
endpackage
`default_nettype wire

// ==== hdl/adcrs_top.sv ====
// Request sequencer and result logic for two successive-approximation converters.
`include "adcrs_regs.svh"
`default_nettype none
module adcrs_top
  import adcrs_pkg::*;
(
  input  wire logic            clk_i,                            // System clock.
  input  wire logic            nrst_i,                           // Synchronous reset, low active.
  input  wire logic [7:0]      addr_i,                           // Register address.
  input  wire logic [15:0]     wdata_i,                          // Write data.
  input  wire logic            wr_i,                             // Write strobe.
  input  wire logic            rd_i,                             // Read strobe.
  output logic      [15:0]     rdata_o,                          // Read data, cycle after rd_i.
  input  wire logic            external_conversion_trigger_in_i, // Trigger pin.
  input  wire logic [1:0]      int_trig_i,                       // On-chip trigger pulses.
  input  wire logic [1:0]      cmp_i,                            // Comparator, high if input at or above DAC.
  input  wire logic [1:0][8:0] pin_i,                            // Digital level of channel pins.
  output logic      [1:0][9:0] dac_o,                            // Trial code to the DAC.
  output logic      [1:0]      sample_o,                         // Sample switch closed.
  output logic      [1:0][3:0] chsel_o,                          // Analog channel select.
  output logic      [1:0][2:0] emux_o,                           // External multiplexer select.
  output logic      [1:0]      bw_pre_o,                         // Broken wire precharge.
  output logic      [1:0]      mux_test_o,                       // Multiplexer test switch.
  output logic      [1:0]      pwr_dn_o,                         // Analog part powered down.
  output logic      [1:0][8:0] dig_en_o,                         // Digital input stage enable.
  output logic      [1:0]      event_req_o,                      // Service request pulse.
  output logic      [1:0][2:0] event_res_o                       // Result register of the request.
);
  adcrs_state_s      s_ff;
  adcrs_state_s      nxt_s;
  adcrs_conv_s       cs;
  logic [2:0]        ev;
  logic [1:0]        hv;
  logic [1:0]        go;
  logic [1:0]        blk;
  logic [1:0]        accfin;
  logic [1:0]        drop;
  logic [1:0][1:0]   best;
  adcrs_src_e [1:0]  src;
  logic [1:0][3:0]   cht;
  logic [1:0][2:0]   tgn;
  logic [1:0][2:0]   tail;
  logic [1:0][13:0]  sum;
  logic [3:0]        pch;
  logic [7:0]        step;
  logic              sync;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.rdata = '0;
    nxt_s.trg = {s_ff.trg[1:0], external_conversion_trigger_in_i};
    ev = {int_trig_i, s_ff.trg[1] & ~s_ff.trg[2]};
    sync = s_ff.cv[0].ctrl[`ADCRS_C_SYNC];
    pch = '0;
    step = '0;
    for (int c = 0; c < 2; c++) begin
      cs = s_ff.cv[c];
      hv[c] = 1'b0;
      best[c] = '0;
      src[c] = SRC_PAR;
      cht[c] = '0;
      tgn[c] = '0;
      pch = '0;
      for (int k = 8; k >= 0; k--) begin
        if (cs.pend[k]) begin
          pch = 4'(k);
        end
      end
      if (|cs.pend) begin
        hv[c] = 1'b1;
        best[c] = cs.ctrl[`ADCRS_C_PPAR+:2];
        cht[c] = pch;
        tgn[c] = pch[2:0];
      end
      if (cs.qrun && cs.qn != 3'h0 && (!hv[c] || cs.ctrl[`ADCRS_C_PQ+:2] >= best[c])) begin
        hv[c] = 1'b1;
        best[c] = cs.ctrl[`ADCRS_C_PQ+:2];
        src[c] = SRC_Q;
        cht[c] = cs.q[0][3:0];
        tgn[c] = cs.q[0][6:4];
      end
      if (cs.ins_p && (!hv[c] || cs.ctrl[`ADCRS_C_PINS+:2] >= best[c])) begin
        hv[c] = 1'b1;
        best[c] = cs.ctrl[`ADCRS_C_PINS+:2];
        src[c] = SRC_INS;
        cht[c] = cs.ins[3:0];
        tgn[c] = cs.ins[6:4];
      end
      tail[c] = cs.tgt;
      for (int k = 0; k < 7; k++) begin
        if (tail[c] != 3'h7 && cs.chain[tail[c]]) begin
          tail[c] = tail[c] + 3'h1;
        end
      end
      blk[c] = cs.val[tail[c]] && cs.wfr[tail[c]];
      sum[c] = cs.acc + (cs.ctrl[`ADCRS_C_RES8] ? {6'h00, cs.sar[7:0]} : {4'h0, cs.sar});
      accfin[c] = cs.accn == 3'((4'h1 << cs.ctrl[`ADCRS_C_ACC+:2]) - 4'h1);
      drop[c] = cs.ctrl[`ADCRS_C_LIM] && sum[c] >= {4'h0, cs.lo} && sum[c] <= {4'h0, cs.hi};
    end
    for (int c = 0; c < 2; c++) begin
      go[c] = hv[c] && s_ff.cv[c].st == ST_IDLE
              && (!sync || (&hv && s_ff.cv[0].st == ST_IDLE && s_ff.cv[1].st == ST_IDLE));
    end
    for (int c = 0; c < 2; c++) begin
      cs = s_ff.cv[c];
      nxt_s.cv[c].din_s1 = pin_i[c];
      nxt_s.cv[c].din_s2 = cs.din_s1;
      nxt_s.cv[c].cmp_s1 = cmp_i[c];
      nxt_s.cv[c].cmp_s2 = cs.cmp_s1;
      nxt_s.cv[c].srq = 1'b0;
      step = (cs.tim[15:8] < `ADCRS_STEP_MIN) ? `ADCRS_STEP_MIN : cs.tim[15:8];
      // Reads come first so that a result stored in the same cycle stays valid.
      if (rd_i && addr_i[7:6] == 2'(c)) begin
        if (addr_i[5:0] == `ADCRS_CTRL) begin
          nxt_s.rdata = cs.ctrl;
        end else if (addr_i[5:0] == `ADCRS_TIM) begin
          nxt_s.rdata = cs.tim;
        end else if (addr_i[5:0] == `ADCRS_PEND) begin
          nxt_s.rdata = {7'h00, cs.pend};
        end else if (addr_i[5:0] == `ADCRS_LDMSK) begin
          nxt_s.rdata = {7'h00, cs.ldmsk};
        end else if (addr_i[5:0] == `ADCRS_QUEUE) begin
          nxt_s.rdata = {cs.qrun, 12'h000, cs.qn};
        end else if (addr_i[5:0] == `ADCRS_INS) begin
          nxt_s.rdata = {7'h00, cs.ins_p, 1'b0, cs.ins};
        end else if (addr_i[5:0] == `ADCRS_LIMLO) begin
          nxt_s.rdata = {6'h00, cs.lo};
        end else if (addr_i[5:0] == `ADCRS_TSEL) begin
          nxt_s.rdata = {7'h00, cs.tsel};
        end else if (addr_i[5:0] == `ADCRS_LIMHI) begin
          nxt_s.rdata = {6'h00, cs.hi};
        end else if (addr_i[5:0] == `ADCRS_RESCFG) begin
          nxt_s.rdata = {cs.chain, cs.wfr};
        end else if (addr_i[5:0] == `ADCRS_SRQSEL) begin
          nxt_s.rdata = {8'h00, cs.srqsel};
        end else if (addr_i[5:0] == `ADCRS_DIGDIS) begin
          nxt_s.rdata = {7'h00, cs.digdis};
        end else if (addr_i[5:0] == `ADCRS_STATUS) begin
          nxt_s.rdata = {cs.val, 1'b0, cs.ch, cs.qrun, cs.ctrl[`ADCRS_C_APD] && cs.st == ST_IDLE, cs.st != ST_IDLE};
        end else if (addr_i[5:0] == `ADCRS_DIGIN) begin
          nxt_s.rdata = {7'h00, cs.din_s2 & ~cs.digdis};
        end else if (addr_i[5:3] == `ADCRS_RES_GRP) begin
          nxt_s.rdata = {cs.val[addr_i[2:0]], 1'b0, cs.res[addr_i[2:0]]};
          nxt_s.cv[c].val[addr_i[2:0]] = 1'b0;
        end
      end
      // Chained registers drain toward the lowest one, which software reads.
      for (int r = 0; r < 7; r++) begin
        if (cs.chain[r] && !nxt_s.cv[c].val[r] && nxt_s.cv[c].val[r+1]) begin
          nxt_s.cv[c].res[r] = nxt_s.cv[c].res[r+1];
          nxt_s.cv[c].val[r] = 1'b1;
          nxt_s.cv[c].val[r+1] = 1'b0;
        end
      end
      case (cs.st)
        ST_IDLE: begin
          if (go[c]) begin
            nxt_s.cv[c].ch = cht[c];
            nxt_s.cv[c].tgt = tgn[c];
            case (src[c])
              SRC_PAR: nxt_s.cv[c].pend[cht[c]] = 1'b0;
              SRC_Q: begin
                for (int k = 0; k < 3; k++) begin
                  nxt_s.cv[c].q[k] = cs.q[k+1];
                end
                nxt_s.cv[c].q[3] = '0;
                nxt_s.cv[c].qn = cs.qn - 3'h1;
              end
              default: nxt_s.cv[c].ins_p = 1'b0;
            endcase
            if (cs.ctrl[`ADCRS_C_APD] || sync) begin
              nxt_s.cv[c].st = ST_WAKE;
              nxt_s.cv[c].cnt = `ADCRS_WAKE_CYC - 8'h01;
            end else begin
              nxt_s.cv[c].st = ST_SAMP;
              nxt_s.cv[c].cnt = cs.tim[7:0];
            end
          end
        end
        ST_WAKE: begin
          nxt_s.cv[c].cnt = cs.cnt - 8'h01;
          if (cs.cnt == 8'h00) begin
            nxt_s.cv[c].st = ST_SAMP;
            nxt_s.cv[c].cnt = cs.tim[7:0];
          end
        end
        ST_SAMP: begin
          nxt_s.cv[c].cnt = cs.cnt - 8'h01;
          if (cs.cnt == 8'h00) begin
            nxt_s.cv[c].st = ST_CONV;
            nxt_s.cv[c].cnt = step - 8'h01;
            nxt_s.cv[c].bitn = cs.ctrl[`ADCRS_C_RES8] ? 4'h7 : 4'h9;
            nxt_s.cv[c].sar = cs.ctrl[`ADCRS_C_RES8] ? 10'h080 : 10'h200;
          end
        end
        ST_CONV: begin
          nxt_s.cv[c].cnt = cs.cnt - 8'h01;
          if (cs.cnt == 8'h00) begin
            nxt_s.cv[c].sar[cs.bitn] = cs.cmp_s2;
            nxt_s.cv[c].cnt = step - 8'h01;
            if (cs.bitn == 4'h0) begin
              nxt_s.cv[c].st = ST_STORE;
            end else begin
              nxt_s.cv[c].bitn = cs.bitn - 4'h1;
              nxt_s.cv[c].sar[cs.bitn-4'h1] = 1'b1;
            end
          end
        end
        ST_STORE: begin
          if (!accfin[c]) begin
            nxt_s.cv[c].acc = sum[c];
            nxt_s.cv[c].accn = cs.accn + 3'h1;
            nxt_s.cv[c].st = ST_IDLE;
          end else if (drop[c]) begin
            nxt_s.cv[c].acc = '0;
            nxt_s.cv[c].accn = '0;
            nxt_s.cv[c].st = ST_IDLE;
          end else if (!blk[c]) begin
            nxt_s.cv[c].res[tail[c]] = sum[c];
            nxt_s.cv[c].val[tail[c]] = 1'b1;
            nxt_s.cv[c].acc = '0;
            nxt_s.cv[c].accn = '0;
            nxt_s.cv[c].srq = cs.srqsel[tail[c]];
            nxt_s.cv[c].srqr = tail[c];
            nxt_s.cv[c].st = ST_IDLE;
          end
        end
        default: nxt_s.cv[c].st = ST_IDLE;
      endcase
      if (nxt_s.cv[c].qn == 3'h0) begin
        nxt_s.cv[c].qrun = 1'b0;
      end
      if (|(ev & cs.tsel[2:0])) begin
        nxt_s.cv[c].pend = nxt_s.cv[c].pend | cs.ldmsk;
      end
      if (|(ev & cs.tsel[5:3])) begin
        nxt_s.cv[c].qrun = 1'b1;
      end
      if (|(ev & cs.tsel[8:6])) begin
        nxt_s.cv[c].ins_p = 1'b1;
      end
      if (wr_i && addr_i[7:6] == 2'(c)) begin
        if (addr_i[5:0] == `ADCRS_CTRL) begin
          nxt_s.cv[c].ctrl = wdata_i;
        end else if (addr_i[5:0] == `ADCRS_TIM) begin
          nxt_s.cv[c].tim = wdata_i;
        end else if (addr_i[5:0] == `ADCRS_PEND) begin
          nxt_s.cv[c].pend = nxt_s.cv[c].pend | wdata_i[8:0];
        end else if (addr_i[5:0] == `ADCRS_LDMSK) begin
          nxt_s.cv[c].ldmsk = wdata_i[8:0];
        end else if (addr_i[5:0] == `ADCRS_QUEUE) begin
          if (nxt_s.cv[c].qn < `ADCRS_QDEPTH) begin
            nxt_s.cv[c].q[nxt_s.cv[c].qn[1:0]] = wdata_i[6:0];
            nxt_s.cv[c].qn = nxt_s.cv[c].qn + 3'h1;
          end
          if (wdata_i[`ADCRS_Q_RUN]) begin
            nxt_s.cv[c].qrun = 1'b1;
          end
        end else if (addr_i[5:0] == `ADCRS_INS) begin
          nxt_s.cv[c].ins = wdata_i[6:0];
          if (wdata_i[`ADCRS_INS_GO]) begin
            nxt_s.cv[c].ins_p = 1'b1;
          end
        end else if (addr_i[5:0] == `ADCRS_LIMLO) begin
          nxt_s.cv[c].lo = wdata_i[9:0];
        end else if (addr_i[5:0] == `ADCRS_TSEL) begin
          nxt_s.cv[c].tsel = wdata_i[8:0];
        end else if (addr_i[5:0] == `ADCRS_LIMHI) begin
          nxt_s.cv[c].hi = wdata_i[9:0];
        end else if (addr_i[5:0] == `ADCRS_RESCFG) begin
          nxt_s.cv[c].wfr = wdata_i[7:0];
          nxt_s.cv[c].chain = wdata_i[15:8];
        end else if (addr_i[5:0] == `ADCRS_SRQSEL) begin
          nxt_s.cv[c].srqsel = wdata_i[7:0];
        end else if (addr_i[5:0] == `ADCRS_DIGDIS) begin
          nxt_s.cv[c].digdis = wdata_i[8:0];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_ff <= '0;
      for (int c = 0; c < 2; c++) begin
        s_ff.cv[c].ctrl <= `ADCRS_CTRL_RST;
        s_ff.cv[c].tim <= `ADCRS_TIM_RST;
      end
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rdata_o = s_ff.rdata;

  for (genvar c = 0; c < 2; c++) begin : g_out
    assign dac_o[c] = s_ff.cv[c].ctrl[`ADCRS_C_RES8] ? {s_ff.cv[c].sar[7:0], 2'b00} : s_ff.cv[c].sar;
    assign sample_o[c] = s_ff.cv[c].st == ST_SAMP;
    assign chsel_o[c] = s_ff.cv[c].ch;
    assign emux_o[c] = s_ff.cv[c].ctrl[`ADCRS_C_EMUX] ? s_ff.cv[c].ch[2:0] : 3'h0;
    assign bw_pre_o[c] = s_ff.cv[c].ctrl[`ADCRS_C_BWD] && s_ff.cv[c].st == ST_SAMP;
    assign mux_test_o[c] = s_ff.cv[c].ctrl[`ADCRS_C_MTEST] && s_ff.cv[c].st != ST_IDLE;
    assign pwr_dn_o[c] = s_ff.cv[c].ctrl[`ADCRS_C_APD] && s_ff.cv[c].st == ST_IDLE;
    assign dig_en_o[c] = ~s_ff.cv[c].digdis;
    assign event_req_o[c] = s_ff.cv[c].srq;
    assign event_res_o[c] = s_ff.cv[c].srqr;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  conv_width_a: assert property ((s_ff.cv[0].st == ST_SAMP) ##1 (s_ff.cv[0].st == ST_CONV)
    |-> s_ff.cv[0].bitn == ($past(s_ff.cv[0].ctrl[`ADCRS_C_RES8]) ? 4'h7 : 4'h9))
    else $error("conversion started with wrong bit count");
  short_res_a: assert property ((s_ff.cv[0].st == ST_STORE && s_ff.cv[0].ctrl[`ADCRS_C_RES8]
    && $past(s_ff.cv[0].ctrl[`ADCRS_C_RES8], 12)) |-> s_ff.cv[0].sar[9:8] == 2'b00)
    else $error("8-bit result uses upper bits");
  samp_len_a: assert property ((s_ff.cv[0].st == ST_SAMP && s_ff.cv[0].cnt != 8'h00)
    |=> s_ff.cv[0].st == ST_SAMP)
    else $error("sample phase ended early");
  sync_start_a: assert property ((sync && go[0]) |=> (s_ff.cv[0].st == ST_WAKE && s_ff.cv[1].st == ST_WAKE))
    else $error("synchronised converters did not start together");
  queue_depth_a: assert property (s_ff.cv[0].qn <= `ADCRS_QDEPTH)
    else $error("queue overfilled");
  hold_off_a: assert property ((s_ff.cv[0].st == ST_STORE && accfin[0] && !drop[0] && blk[0])
    |=> s_ff.cv[0].st == ST_STORE)
    else $error("blocked conversion was not held");
  srq_src_a: assert property (event_req_o[0] |-> $past(s_ff.cv[0].st) == ST_STORE
    && s_ff.cv[0].val[event_res_o[0]])
    else $error("service request without stored result");
  wake_len_a: assert property ((go[0] && s_ff.cv[0].ctrl[`ADCRS_C_APD])
    |=> (s_ff.cv[0].st == ST_WAKE && !pwr_dn_o[0])[*4] ##1 s_ff.cv[0].st == ST_SAMP)
    else $error("power-up sequence wrong");
  read_clear_a: assert property ((rd_i && addr_i == 8'h10 && s_ff.cv[0].st != ST_STORE
    && !s_ff.cv[0].chain[0]) |=> !s_ff.cv[0].val[0])
    else $error("read did not clear valid flag");
endmodule
`default_nettype wire

// ==== tb/adcrs_sensor.sv ====
// Behavioural analog sources and comparator in front of one converter.
`default_nettype none
module adcrs_sensor (
  input  wire logic [8:0][9:0] lvl_i,   // Analog level of each channel.
  input  wire logic [3:0]      chsel_i, // Channel switched to the comparator.
  input  wire logic [9:0]      dac_i,   // Trial code from the converter.
  output logic                 cmp_o,   // High when level is at or above code.
  output logic      [8:0]      pin_o    // Digital view of each channel pin.
);
  timeunit 1ns;
  timeprecision 100ps;
  // An unselected channel code leaves the comparator input at ground.
  always_comb begin
    cmp_o = (chsel_i <= 4'h8) ? (lvl_i[chsel_i] >= dac_i) : 1'b0;
    for (int i = 0; i < 9; i++) begin
      pin_o[i] = lvl_i[i][9];
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_adc_request_sequencer.sv ====
// Self-checking bench of the converter request sequencer.
`include "adcrs_regs.svh"
`default_nettype none
module tb_adc_request_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic       c;
    logic [3:0] ch;
    logic [9:0] lv;
    logic       r8;
    logic [9:0] ex;
  } adcrs_row_s;
  localparam adcrs_row_s ROWS [6] = '{
    '{1'b0, 4'h0, 10'h000, 1'b0, 10'h000}, '{1'b0, 4'h3, 10'h2a5, 1'b0, 10'h2a5},
    '{1'b0, 4'h8, 10'h3ff, 1'b0, 10'h3ff}, '{1'b1, 4'h5, 10'h155, 1'b0, 10'h155},
    '{1'b1, 4'h2, 10'h2a7, 1'b1, 10'h0a9}, '{1'b0, 4'h7, 10'h3ff, 1'b1, 10'h0ff}};
  logic                 clk = 1'b0;
  logic                 nrst = 1'b0;
  logic [7:0]           addr = 8'h00;
  logic [15:0]          wdata = 16'h0000;
  logic                 wr_s = 1'b0;
  logic                 rd_s = 1'b0;
  logic                 trg = 1'b0;
  logic [1:0]           itrg = 2'h0;
  logic [1:0][8:0][9:0] lvl = '0;
  logic [15:0]          rdata;
  logic [1:0]           cmp;
  logic [1:0][8:0]      pin;
  logic [1:0][9:0]      dac;
  logic [1:0][3:0]      chsel;
  logic [1:0][2:0]      emux;
  logic [1:0]           pdn;
  logic [1:0]           smp;
  logic [1:0]           bwp;
  logic [1:0]           mxt;
  logic [1:0][8:0]      den;
  logic [1:0]           evr;
  logic [1:0][2:0]      evres;
  logic [3:0]           evq[$];
  logic [15:0]          d;
  int                   bad_count = 0;
  int                   compares = 0;
  int                   both_n = 0;
  int                   bwp_n = 0;
  int                   mxt_n = 0;
  int                   n0;
  int                   n1;
  int                   n2;
  always #2.5 clk = ~clk;
  adcrs_top DUT (.clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
    .rdata_o(rdata), .external_conversion_trigger_in_i(trg), .int_trig_i(itrg), .cmp_i(cmp), .pin_i(pin),
    .dac_o(dac), .sample_o(smp), .chsel_o(chsel), .emux_o(emux), .bw_pre_o(bwp), .mux_test_o(mxt), .pwr_dn_o(pdn),
    .dig_en_o(den), .event_req_o(evr), .event_res_o(evres));
  for (genvar g = 0; g < 2; g++) begin : g_sns
    adcrs_sensor SNS (.lvl_i(lvl[g]), .chsel_i(chsel[g]), .dac_i(dac[g]), .cmp_o(cmp[g]), .pin_o(pin[g]));
  end
  always @(negedge clk) begin
    for (int c = 0; c < 2; c++) begin
      if (evr[c] === 1'b1) begin
        evq.push_back({c[0], evres[c]});
      end
    end
    // Cycle counts of both converters sampling at once and of the precharge and test phases of converter 0, read as differences by the tests.
    if (smp === 2'b11) both_n++;
    if (bwp[0] === 1'b1) bwp_n++;
    if (mxt[0] === 1'b1) mxt_n++;
  end
  function automatic logic [7:0] ad(input logic c, input logic [5:0] o);
    return {1'b0, c, o};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wait_val(input logic c, input logic [2:0] r);
    logic [15:0] v;
    for (int i = 0; i < 300; i++) begin
      rd(ad(c, `ADCRS_STATUS), v);
      if (v[8+r] === 1'b1) return;
    end
    bad_count++;
    summarize();
  endtask
  task automatic chk_ev(input logic [3:0] exp);
    for (int i = 0; i < 900 && evq.size() == 0; i++) @(posedge clk);
    if (evq.size() == 0) begin
      bad_count++;
      summarize();
    end
    chk({12'h000, evq.pop_front()}, {12'h000, exp});
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk({7'h00, den[0]}, 16'h01ff);
    rchk(ad(0, `ADCRS_CTRL), `ADCRS_CTRL_RST);
    rchk(ad(1, `ADCRS_TIM), `ADCRS_TIM_RST);
    wr(8'hc0, 16'hffff);
    rchk(8'hc0, 16'h0000);
    wr(ad(0, `ADCRS_SRQSEL), 16'h00ff);
    wr(ad(1, `ADCRS_SRQSEL), 16'h00ff);
    $display("test reset done");
    foreach (ROWS[i]) begin
      lvl[ROWS[i].c][ROWS[i].ch] = ROWS[i].lv;
      wr(ad(ROWS[i].c, `ADCRS_CTRL), {15'h0000, ROWS[i].r8});
      wr(ad(ROWS[i].c, `ADCRS_PEND), 16'h0001 << ROWS[i].ch);
      wait_val(ROWS[i].c, ROWS[i].ch[2:0]);
      rchk(ad(ROWS[i].c, {3'b010, ROWS[i].ch[2:0]}), {6'h20, ROWS[i].ex});
      chk_ev({ROWS[i].c, ROWS[i].ch[2:0]});
    end
    $display("test rows done");
    wr(ad(0, `ADCRS_CTRL), 16'h0000);
    lvl[0][2] = 10'h011;
    lvl[0][5] = 10'h3c0;
    wr(ad(0, `ADCRS_PEND), 16'h0024);
    chk_ev(4'h2);
    chk_ev(4'h5);
    rchk(ad(0, 6'h12), 16'h8011);
    rchk(ad(0, 6'h15), 16'h83c0);
    $display("test parallel order done");
    wr(ad(0, `ADCRS_QUEUE), 16'h0016);
    wr(ad(0, `ADCRS_QUEUE), 16'h8043);
    wr(ad(0, `ADCRS_INS), 16'h0172);
    chk_ev(4'h1);
    chk_ev(4'h7);
    chk_ev(4'h4);
    $display("test queue and insert done");
    wr(ad(1, `ADCRS_CTRL), 16'h4400);
    wr(ad(1, `ADCRS_LDMSK), 16'h0002);
    wr(ad(1, `ADCRS_TSEL), 16'h0009);
    wr(ad(1, `ADCRS_QUEUE), 16'h0064);
    @(posedge clk);
    trg <= 1'b1;
    repeat (3) @(posedge clk);
    trg <= 1'b0;
    chk_ev(4'he);
    chk_ev(4'h9);
    @(negedge clk);
    chk({13'h0000, emux[1]}, 16'h0001);
    $display("test trigger and priority done");
    wr(ad(0, `ADCRS_RESCFG), 16'h0008);
    lvl[0][3] = 10'h100;
    wr(ad(0, `ADCRS_PEND), 16'h0008);
    wait_val(1'b0, 3'h3);
    chk_ev(4'h3);
    lvl[0][3] = 10'h200;
    wr(ad(0, `ADCRS_PEND), 16'h0008);
    repeat (150) @(posedge clk);
    rchk(ad(0, 6'h13), 16'h8100);
    wait_val(1'b0, 3'h3);
    chk_ev(4'h3);
    rchk(ad(0, 6'h13), 16'h8200);
    rd(ad(0, `ADCRS_STATUS), d);
    chk(d & 16'h0800, 16'h0000);
    $display("test wait for read done");
    wr(ad(1, `ADCRS_DIGDIS), 16'h00f0);
    @(negedge clk);
    chk({7'h00, den[1]}, 16'h010f);
    repeat (3) @(posedge clk);
    rchk(ad(1, `ADCRS_DIGIN), {7'h00, pin[1] & 9'h10f});
    wr(ad(1, `ADCRS_CTRL), 16'h0002);
    @(negedge clk);
    chk({15'h0000, pdn[1]}, 16'h0001);
    $display("test pins and power done");
    rchk(ad(1, 6'h11), 16'h8000);
    wr(ad(1, `ADCRS_RESCFG), 16'h0100);
    wr(ad(1, `ADCRS_CTRL), 16'h0040);
    lvl[1][0] = 10'h123;
    wr(ad(1, `ADCRS_QUEUE), 16'h0000);
    wr(ad(1, `ADCRS_QUEUE), 16'h8000);
    chk_ev(4'h9);
    lvl[1][0] = 10'h301;
    wr(ad(1, `ADCRS_QUEUE), 16'h0000);
    wr(ad(1, `ADCRS_QUEUE), 16'h8000);
    chk_ev(4'h9);
    rchk(ad(1, 6'h10), 16'h8246);
    rchk(ad(1, 6'h10), 16'h8602);
    wr(ad(1, `ADCRS_CTRL), 16'h0020);
    wr(ad(1, `ADCRS_LIMLO), 16'h0100);
    wr(ad(1, `ADCRS_LIMHI), 16'h0200);
    lvl[1][2] = 10'h180;
    lvl[1][5] = 10'h050;
    wr(ad(1, `ADCRS_PEND), 16'h0024);
    chk_ev(4'hd);
    rchk(ad(1, 6'h15), 16'h8050);
    $display("test chain and reduction done");
    wr(ad(0, `ADCRS_TSEL), 16'h0080);
    wr(ad(0, `ADCRS_INS), 16'h0066);
    lvl[0][6] = 10'h0aa;
    @(posedge clk);
    itrg <= 2'b01;
    @(posedge clk);
    itrg <= 2'b00;
    chk_ev(4'h6);
    rchk(ad(0, 6'h16), 16'h80aa);
    $display("test on-chip trigger done");
    wr(ad(0, `ADCRS_CTRL), 16'h001e);
    lvl[0][1] = 10'h0c3;
    lvl[1][4] = 10'h2f0;
    n0 = both_n;
    n1 = bwp_n;
    n2 = mxt_n;
    wr(ad(0, `ADCRS_PEND), 16'h0002);
    wr(ad(1, `ADCRS_PEND), 16'h0010);
    chk_ev(4'h1);
    chk_ev(4'hc);
    @(negedge clk);
    chk(16'(both_n - n0), 16'h0004);
    chk(16'(bwp_n - n1), 16'h0004);
    chk(16'(mxt_n - n2), 16'h0027);
    chk({15'h0000, pdn[0]}, 16'h0001);
    rchk(ad(0, 6'h11), 16'h80c3);
    rchk(ad(1, 6'h14), 16'h82f0);
    $display("test sync and diagnostics done");
    summarize();
  end
endmodule
`default_nettype wire
